// >>> rtl/ptic_consts.vh
// Constants for the paired timer with input capture
`ifndef PTIC_CONSTS_VH
`define PTIC_CONSTS_VH
// Register byte addresses
`define PTIC_ADDR_LCON     12'h000
`define PTIC_ADDR_HCON     12'h004
`define PTIC_ADDR_LCOUNT   12'h008
`define PTIC_ADDR_HCOUNT   12'h00C
`define PTIC_ADDR_LPER     12'h010
`define PTIC_ADDR_HPER     12'h014
`define PTIC_ADDR_CCON     12'h018
`define PTIC_ADDR_CBUF     12'h01C
`define PTIC_ADDR_STAT     12'h020
// Timer control fields
`define PTIC_T_RUN         15
`define PTIC_T_IDLE        13
`define PTIC_T_GATE        6
`define PTIC_T_PSH         5
`define PTIC_T_PSL         4
`define PTIC_T_JOIN        3
`define PTIC_T_CS          1
`define PTIC_LCON_MASK     16'hA07A
`define PTIC_HCON_MASK     16'hA072
// Capture control fields
`define PTIC_C_IDLE        13
`define PTIC_C_TSEL        7
`define PTIC_C_CPIH        6
`define PTIC_C_CPIL        5
`define PTIC_C_OVF         4
`define PTIC_C_NE          3
`define PTIC_CCON_MASK     16'h20E7
// Capture modes
`define PTIC_CM_OFF        3'h0
`define PTIC_CM_EDGE       3'h1
`define PTIC_CM_FALL       3'h2
`define PTIC_CM_RISE       3'h3
`define PTIC_CM_RISE4      3'h4
`define PTIC_CM_RISE16     3'h5
`define PTIC_CM_UNUSED     3'h6
`define PTIC_CM_WAKE       3'h7
// Reset values
`define PTIC_RST_CON       16'h0000
`define PTIC_RST_PER       16'hFFFF
// Status register bits
`define PTIC_S_LMATCH      0
`define PTIC_S_HMATCH      1
`define PTIC_S_CAP         2
`define PTIC_S_WAKE        3
`endif

// >>> rtl/ptic_top.v
// Paired 16/32-bit timer with four-deep input capture, APB slave
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ptic_consts.vh"
module ptic_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        cpu_idle,
    input  wire        cpu_sleep,
    input  wire        low_clk_pin,
    input  wire        high_clk_pin,
    input  wire        low_gate_pin,
    input  wire        high_gate_pin,
    input  wire        capture_pin,
    output reg         low_match_pulse,
    output reg         high_match_pulse,
    output reg         adc_trigger,
    output reg         capture_irq,
    output reg         capture_wake
);
    // =========================================================
    // Registers
    reg  [15:0] low_timer_control_reg;
    reg  [15:0] high_timer_control_reg;
    reg  [15:0] low_count_reg;
    reg  [15:0] high_count_reg;
    reg  [15:0] low_period_reg;
    reg  [15:0] high_period_reg;
    reg  [7:0]  capture_control_reg;
    reg         capture_idle_stop_reg;
    reg  [15:0] fifo_mem [0:3];
    reg  [1:0]  fifo_wr_reg;
    reg  [1:0]  fifo_rd_reg;
    reg  [2:0]  fifo_cnt_reg;
    reg         capture_overflow_reg;
    reg  [3:0]  sticky_reg;
    reg  [1:0]  irq_cnt_reg;
    reg  [3:0]  edge_cnt_reg;
    reg  [7:0]  low_pre_reg;
    reg  [7:0]  high_pre_reg;
    // Two-flop synchronisers for all pins, plus one delayed copy
    reg  [4:0]  pin_s1_reg;
    reg  [4:0]  pin_s2_reg;
    reg  [4:0]  pin_d_reg;
    wire [4:0]  pin_raw = {capture_pin, high_gate_pin, low_gate_pin,
                           high_clk_pin, low_clk_pin};
    wire [4:0]  pin_rise = pin_s2_reg & ~pin_d_reg;
    wire [4:0]  pin_fall = ~pin_s2_reg & pin_d_reg;

    // Prescale terminal value for a 2-bit field
    function [7:0] ptic_div;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    ptic_div = 8'h00;
                2'h1:    ptic_div = 8'h07;
                2'h2:    ptic_div = 8'h3F;
                default: ptic_div = 8'hFF;
            endcase
        end
    endfunction

    // =========================================================
    // Timer input events
    wire join_sel = low_timer_control_reg[`PTIC_T_JOIN];
    wire [15:0] lc = low_timer_control_reg;
    wire [15:0] hc = high_timer_control_reg;
    // Internal clock is one tick per pclk; pin counts synchronised
    // rising edges, so no asynchronous counter exists
    wire l_src = lc[`PTIC_T_CS] ? pin_rise[0] :
                 (!lc[`PTIC_T_GATE] | pin_s2_reg[2]);
    wire h_src = hc[`PTIC_T_CS] ? pin_rise[1] :
                 (!hc[`PTIC_T_GATE] | pin_s2_reg[3]);
    wire l_on = lc[`PTIC_T_RUN] &
                !(cpu_idle & lc[`PTIC_T_IDLE]);
    wire h_on = hc[`PTIC_T_RUN] &
                !(cpu_idle & hc[`PTIC_T_IDLE]);
    wire l_in = l_on & l_src;
    wire h_in = h_on & h_src & !join_sel;
    wire l_tick = l_in &
        (low_pre_reg == ptic_div(lc[`PTIC_T_PSH:`PTIC_T_PSL]));
    wire h_tick = h_in &
        (high_pre_reg == ptic_div(hc[`PTIC_T_PSH:`PTIC_T_PSL]));
    wire l_match = (low_count_reg == low_period_reg);
    wire h_match = (high_count_reg == high_period_reg);
    wire j_match = l_match & h_match;

    // Prescalers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_pre_reg  <= 8'h00;
            high_pre_reg <= 8'h00;
        end
        else
        begin
            if (!l_on)
                low_pre_reg <= 8'h00;
            else if (l_in)
                low_pre_reg <= l_tick ? 8'h00 : low_pre_reg + 8'h01;
            if (!h_on | join_sel)
                high_pre_reg <= 8'h00;
            else if (h_in)
                high_pre_reg <= h_tick ? 8'h00 : high_pre_reg + 8'h01;
        end
    end

    // =========================================================
    // APB decode
    wire acc   = psel & penable;
    wire wr_en = acc & pwrite;
    wire rd_en = acc & !pwrite;
    wire a_ok  = (paddr[1:0] == 2'h0) && (paddr <= `PTIC_ADDR_STAT);
    wire fifo_pop = rd_en & (paddr == `PTIC_ADDR_CBUF) &
                    (fifo_cnt_reg != 3'h0);
    wire [15:0] wd = pwdata[15:0];

    // =========================================================
    // Capture event generation
    wire [2:0] cmode = capture_control_reg[2:0];
    wire c_halt = cpu_idle & capture_idle_stop_reg;
    wire c_rise = pin_rise[4];
    wire c_fall = pin_fall[4];
    reg  c_evt;
    reg  [3:0] edge_next;
    // Mode decode and edge prescaler
    always @*
    begin
        c_evt = 1'b0;
        edge_next = edge_cnt_reg;
        case (cmode)
            `PTIC_CM_EDGE: c_evt = c_rise | c_fall;
            `PTIC_CM_FALL: c_evt = c_fall;
            `PTIC_CM_RISE: c_evt = c_rise;
            `PTIC_CM_RISE4:
            begin
                if (c_rise)
                    edge_next = edge_cnt_reg + 4'h1;
                c_evt = c_rise & (edge_cnt_reg[1:0] == 2'h3);
            end
            `PTIC_CM_RISE16:
            begin
                if (c_rise)
                    edge_next = edge_cnt_reg + 4'h1;
                c_evt = c_rise & (edge_cnt_reg == 4'hF);
            end
            default:
            begin
                c_evt = 1'b0;
                edge_next = 4'h0;
            end
        endcase
        if (c_halt)
        begin
            c_evt = 1'b0;
            edge_next = edge_cnt_reg;
        end
    end
    wire fifo_full = (fifo_cnt_reg == 3'h4);
    wire c_push = c_evt & (!fifo_full | fifo_pop);
    wire [15:0] cap_val = capture_control_reg[`PTIC_C_TSEL] ?
                          low_count_reg : high_count_reg;
    wire [1:0] cpi = capture_control_reg[`PTIC_C_CPIH:`PTIC_C_CPIL];
    wire cap_int = c_push & ((cmode == `PTIC_CM_EDGE) |
                             (irq_cnt_reg == cpi));
    wire wake_evt = (cmode == `PTIC_CM_WAKE) & c_rise &
                    (cpu_idle | cpu_sleep);

    // =========================================================
    // Pin synchronisers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_reg <= 5'h00;
            pin_s2_reg <= 5'h00;
            pin_d_reg  <= 5'h00;
        end
        else
        begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg  <= pin_s2_reg;
        end
    end

    // =========================================================
    // Control registers, counters and capture state
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_timer_control_reg  <= `PTIC_RST_CON;
            high_timer_control_reg <= `PTIC_RST_CON;
            low_count_reg          <= 16'h0000;
            high_count_reg         <= 16'h0000;
            low_period_reg         <= `PTIC_RST_PER;
            high_period_reg        <= `PTIC_RST_PER;
            capture_control_reg    <= 8'h00;
            capture_idle_stop_reg  <= 1'b0;
            fifo_wr_reg            <= 2'h0;
            fifo_rd_reg            <= 2'h0;
            fifo_cnt_reg           <= 3'h0;
            capture_overflow_reg   <= 1'b0;
            irq_cnt_reg            <= 2'h0;
            edge_cnt_reg           <= 4'h0;
            sticky_reg             <= 4'h0;
        end
        else
        begin
            // Counting: joined pair or two independent halves
            if (join_sel)
            begin
                if (l_tick)
                begin
                    if (j_match)
                    begin
                        low_count_reg  <= 16'h0000;
                        high_count_reg <= 16'h0000;
                    end
                    else
                    begin
                        low_count_reg <= low_count_reg + 16'h0001;
                        if (low_count_reg == 16'hFFFF)
                            high_count_reg <= high_count_reg + 16'h0001;
                    end
                end
            end
            else
            begin
                if (l_tick)
                    low_count_reg <= l_match ? 16'h0000 :
                                     low_count_reg + 16'h0001;
                if (h_tick)
                    high_count_reg <= h_match ? 16'h0000 :
                                      high_count_reg + 16'h0001;
            end
            // Capture buffer push and pop
            if (c_push)
            begin
                fifo_wr_reg <= fifo_wr_reg + 2'h1;
                irq_cnt_reg <= (cap_int) ? 2'h0 : irq_cnt_reg + 2'h1;
            end
            if (fifo_pop)
                fifo_rd_reg <= fifo_rd_reg + 2'h1;
            if (c_push & !fifo_pop)
                fifo_cnt_reg <= fifo_cnt_reg + 3'h1;
            else if (fifo_pop & !c_push)
                fifo_cnt_reg <= fifo_cnt_reg - 3'h1;
            edge_cnt_reg <= edge_next;
            // Overflow set on a discarded event, cleared when drained
            if (c_evt & fifo_full & !fifo_pop)
                capture_overflow_reg <= 1'b1;
            else if (fifo_cnt_reg == 3'h0)
                capture_overflow_reg <= 1'b0;
            // Software writes
            if (wr_en)
            begin
                case (paddr)
                    `PTIC_ADDR_LCON:
                        low_timer_control_reg <= wd & `PTIC_LCON_MASK;
                    `PTIC_ADDR_HCON:
                        high_timer_control_reg <= wd & `PTIC_HCON_MASK;
                    `PTIC_ADDR_LCOUNT: low_count_reg  <= wd;
                    `PTIC_ADDR_HCOUNT: high_count_reg <= wd;
                    `PTIC_ADDR_LPER:   low_period_reg  <= wd;
                    `PTIC_ADDR_HPER:   high_period_reg <= wd;
                    `PTIC_ADDR_CCON:
                    begin
                        capture_idle_stop_reg <= wd[`PTIC_C_IDLE];
                        capture_control_reg   <= wd[7:0] & 8'hE7;
                        if (wd[2:0] == `PTIC_CM_OFF)
                        begin
                            fifo_wr_reg          <= 2'h0;
                            fifo_rd_reg          <= 2'h0;
                            fifo_cnt_reg         <= 3'h0;
                            capture_overflow_reg <= 1'b0;
                            irq_cnt_reg          <= 2'h0;
                            edge_cnt_reg         <= 4'h0;
                        end
                    end
                    default: ;
                endcase
            end
            // Sticky status: write one to clear, a new event wins
            sticky_reg <= (sticky_reg &
                ~((wr_en && paddr == `PTIC_ADDR_STAT) ? wd[3:0] : 4'h0))
                | {wake_evt, cap_int,
                   join_sel ? (l_tick & j_match) : (h_tick & h_match),
                   !join_sel & l_tick & l_match};
        end
    end

    // Capture storage
    always @(posedge pclk)
    begin
        if (c_push)
            fifo_mem[fifo_wr_reg] <= cap_val;
    end

    // =========================================================
    // Read data, pulses and handshake
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata           <= 32'h00000000;
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            low_match_pulse  <= 1'b0;
            high_match_pulse <= 1'b0;
            adc_trigger      <= 1'b0;
            capture_irq      <= 1'b0;
            capture_wake     <= 1'b0;
        end
        else
        begin
            pready  <= psel & !penable;
            pslverr <= psel & !penable & !a_ok;
            prdata  <= 32'h00000000;
            if (psel & !penable & !pwrite)
            begin
                case (paddr)
                    `PTIC_ADDR_LCON:
                        prdata[15:0] <= low_timer_control_reg;
                    `PTIC_ADDR_HCON:
                        prdata[15:0] <= high_timer_control_reg;
                    `PTIC_ADDR_LCOUNT: prdata[15:0] <= low_count_reg;
                    `PTIC_ADDR_HCOUNT: prdata[15:0] <= high_count_reg;
                    `PTIC_ADDR_LPER:   prdata[15:0] <= low_period_reg;
                    `PTIC_ADDR_HPER:   prdata[15:0] <= high_period_reg;
                    `PTIC_ADDR_CCON:
                        prdata[15:0] <= {2'h0, capture_idle_stop_reg,
                            5'h00, capture_control_reg[7:5],
                            capture_overflow_reg,
                            fifo_cnt_reg != 3'h0,
                            capture_control_reg[2:0]};
                    `PTIC_ADDR_CBUF:
                        prdata[15:0] <= fifo_mem[fifo_rd_reg];
                    `PTIC_ADDR_STAT: prdata[3:0] <= sticky_reg;
                    default: ;
                endcase
            end
            low_match_pulse  <= !join_sel & l_tick & l_match;
            high_match_pulse <= join_sel ? (l_tick & j_match) :
                                (h_tick & h_match);
            adc_trigger      <= join_sel ? (l_tick & j_match) :
                                (h_tick & h_match);
            capture_irq      <= cap_int;
            capture_wake     <= wake_evt;
        end
    end
endmodule // ptic_top
`default_nettype wire

// >>> test/ptic_properties.sv
// Concurrent checks on the ports of the paired timer block
`timescale 1ns/100ps
`default_nettype none
`include "ptic_consts.vh"
module ptic_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cpu_idle,
    input wire logic        cpu_sleep,
    input wire logic        low_match_pulse,
    input wire logic        high_match_pulse,
    input wire logic        adc_trigger,
    input wire logic        capture_irq,
    input wire logic        capture_wake
);
    // ====
    // Shadows of completed control writes
    logic [15:0] lcon_q;
    logic [2:0]  cmode_q;
    wire  logic  wr_done = psel && penable && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lcon_q  <= 16'h0000;
            cmode_q <= 3'h0;
        end
        else if (wr_done && paddr == `PTIC_ADDR_LCON)
            lcon_q <= pwdata[15:0];
        else if (wr_done && paddr == `PTIC_ADDR_CCON)
            cmode_q <= pwdata[2:0];
    end

    // ====
    // Properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence run_off_hold;
        (!lcon_q[15])[*6];
    endsequence

    apb_answer_a: assert property (apb_setup |=> pready)
        else $error("No ready after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("Ready too long");
    err_unmapped_a: assert property (apb_setup and paddr > 12'h020
        |=> pslverr && pready) else $error("Unmapped not refused");
    idle_bus_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("Data outside access");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("Upper bits set");
    adc_follow_a: assert property (adc_trigger == high_match_pulse)
        else $error("Trigger differs");
    join_quiet_a: assert property (lcon_q[3] && $past(lcon_q[3], 4)
        |-> !low_match_pulse) else $error("Low match while joined");
    run_quiet_a: assert property (run_off_hold |=> !low_match_pulse)
        else $error("Low match while stopped");
    idle_quiet_a: assert property ((lcon_q[13] && cpu_idle)[*6]
        |=> !low_match_pulse) else $error("Low match in idle");
    cap_quiet_a: assert property ((cmode_q inside {0, 6, 7})[*6]
        |=> !capture_irq) else $error("Capture irq while off");
    wake_mode_a: assert property ((cmode_q != 3'h7)[*6]
        |=> !capture_wake) else $error("Wake outside mode");
    wake_awake_a: assert property ((!cpu_idle && !cpu_sleep)[*6]
        |=> !capture_wake) else $error("Wake while running");
endmodule // ptic_properties
`default_nettype wire

// >>> test/ptic_pin_model.sv
// Pin-side model: external clock, gate and capture inputs
`timescale 1ns/100ps
`default_nettype none
module ptic_pin_model (
    input  wire logic pclk,
    output var  logic low_clk_pin,
    output var  logic high_clk_pin,
    output var  logic low_gate_pin,
    output var  logic high_gate_pin,
    output var  logic capture_pin
);
    // ====
    // Pins idle low and stand still between commands
    initial
    begin
        low_clk_pin   = 1'b0;
        high_clk_pin  = 1'b0;
        low_gate_pin  = 1'b0;
        high_gate_pin = 1'b0;
        capture_pin   = 1'b0;
    end

    // Wide pulses, each edge seen once
    task automatic clk_edges(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            low_clk_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            low_clk_pin <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    // Capture pulses, rising edges ten clocks apart
    task automatic cap_edges(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            capture_pin <= 1'b1;
            repeat (5) @(posedge pclk);
            capture_pin <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    // Gate level for gated accumulation
    task automatic set_gate(input logic g);
        @(posedge pclk);
        low_gate_pin <= g;
    endtask
endmodule // ptic_pin_model
`default_nettype wire

// >>> test/paired_timer_with_input_capture_tb.sv
// Self-checking bench for the paired timer block
`timescale 1ns/100ps
`default_nettype none
`include "ptic_consts.vh"
module paired_timer_with_input_capture_tb;
    // ====
    // Signals and tables
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0;
    logic        cpu_idle = 1'b0, cpu_sleep = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, low_clk_pin, high_clk_pin, low_gate_pin;
    wire         high_gate_pin, capture_pin, low_match_pulse;
    wire         high_match_pulse, adc_trigger, capture_irq, capture_wake;
    int          miscompares = 0, total_checks = 0, cycles = 0;
    int          irq_n = 0, wake_n = 0;
    logic [11:0] rst_addr [0:6] = '{`PTIC_ADDR_LCON, `PTIC_ADDR_HCON,
        `PTIC_ADDR_LCOUNT, `PTIC_ADDR_HCOUNT, `PTIC_ADDR_LPER,
        `PTIC_ADDR_HPER, `PTIC_ADDR_CCON};
    logic [31:0] rst_val [0:6] = '{32'h0, 32'h0, 32'h0, 32'h0,
        32'hFFFF, 32'hFFFF, 32'h0};
    logic [15:0] md_con [0:10] = '{16'h0060, 16'h0061, 16'h0062, 16'h0003,
        16'h0023, 16'h0043, 16'h0064, 16'h0065, 16'h0066, 16'h0067, 16'h2063};
    int          md_pulse [0:10] = '{2, 2, 2, 2, 2, 3, 4, 16, 2, 2, 2};
    int          md_caps [0:10] = '{0, 4, 2, 2, 2, 3, 1, 1, 0, 0, 0};
    int          md_irq [0:10] = '{0, 4, 0, 2, 1, 1, 0, 0, 0, 0, 0};

    ptic_top DUT (.*);
    ptic_pin_model PINS (.*);

    // ====
    // Clock, event counters and hang limit
    always #50 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (capture_irq === 1'b1)
            irq_n <= irq_n + 1;
        if (capture_wake === 1'b1)
            wake_n <= wake_n + 1;
        if (cycles == 90000)
        begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    end

    // ====
    // Shared tasks
    task give_verdict;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check(input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t exp %h got %h", $time, exp, got);
        end
    endtask
    // One APB transfer; request held until ready is sampled high
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            miscompares++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask
    task rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
    endtask
    // Cycles to the next match pulse
    task wait_pulse(input logic hi, output int n);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while ((hi ? high_match_pulse : low_match_pulse) !== 1'b1
               && n < 70000);
    endtask

    // ====
    // Scenarios
    task t_reset;
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 7; i++)
        begin
            rd(rst_addr[i], r);
            check(rst_val[i], r);
        end
        apb(12'h024, 1'b0, 32'h0, r, e);
        check(32'h1, {31'h0, e});
        $display("reset and map test done");
    endtask
    task t_prescale;
        logic [31:0] r;
        int          g;
        int          div [0:3] = '{1, 8, 64, 256};
        wr(`PTIC_ADDR_LPER, 32'h1);
        for (int ps = 0; ps < 4; ps++)
        begin
            wr(`PTIC_ADDR_LCON, 32'h8000 | (ps << 4));
            wait_pulse(1'b0, g);
            wait_pulse(1'b0, g);
            wait_pulse(1'b0, g);
            check(2 * div[ps], g);
        end
        wr(`PTIC_ADDR_LCON, 32'h0);
        wr(`PTIC_ADDR_LCOUNT, 32'h0);
        repeat (20) @(posedge pclk);
        rd(`PTIC_ADDR_LCOUNT, r);
        check(32'h0, r);
        wr(`PTIC_ADDR_HPER, 32'h2);
        wr(`PTIC_ADDR_HCON, 32'h8000);
        wait_pulse(1'b1, g);
        wait_pulse(1'b1, g);
        check(32'h3, g);
        wr(`PTIC_ADDR_HCON, 32'h0);
        $display("prescale test done");
    endtask
    task t_join;
        logic [31:0] r;
        int          n;
        wr(`PTIC_ADDR_HCOUNT, 32'h0);
        wr(`PTIC_ADDR_HPER, 32'h1);
        wr(`PTIC_ADDR_LPER, 32'h40);
        wr(`PTIC_ADDR_HCON, 32'h0030);
        wr(`PTIC_ADDR_LCON, 32'h8008);
        n = 0;
        do
        begin
            rd(`PTIC_ADDR_HCOUNT, r);
            n++;
        end
        while (r !== 32'h1 && n < 30000);
        rd(`PTIC_ADDR_LCOUNT, r);
        check(32'h1, {31'h0, r < 32'h10});
        wait_pulse(1'b1, n);
        check(32'h1, {31'h0, n < 80});
        wr(`PTIC_ADDR_LCON, 32'h0);
        $display("joined timer test done");
    endtask
    task t_gate_ext;
        logic [31:0] r;
        wr(`PTIC_ADDR_LPER, 32'hFFFF);
        wr(`PTIC_ADDR_LCOUNT, 32'h0);
        wr(`PTIC_ADDR_LCON, 32'h8040);
        repeat (30) @(posedge pclk);
        rd(`PTIC_ADDR_LCOUNT, r);
        check(32'h0, r);
        PINS.set_gate(1'b1);
        repeat (30) @(posedge pclk);
        rd(`PTIC_ADDR_LCOUNT, r);
        check(32'h1, {31'h0, r > 32'h10});
        PINS.set_gate(1'b0);
        wr(`PTIC_ADDR_LCON, 32'h0);
        wr(`PTIC_ADDR_LCOUNT, 32'h0);
        wr(`PTIC_ADDR_LCON, 32'h8042);
        PINS.clk_edges(5);
        repeat (8) @(posedge pclk);
        rd(`PTIC_ADDR_LCOUNT, r);
        check(32'h5, r);
        wr(`PTIC_ADDR_LCON, 32'h0);
        $display("gate and pin clock test done");
    endtask
    task t_idle;
        logic [31:0] r;
        int          g;
        wr(`PTIC_ADDR_LPER, 32'h3);
        wr(`PTIC_ADDR_LCOUNT, 32'h0);
        cpu_idle <= 1'b1;
        wr(`PTIC_ADDR_LCON, 32'hA000);
        repeat (10) @(posedge pclk);
        rd(`PTIC_ADDR_LCOUNT, r);
        check(32'h0, r);
        wr(`PTIC_ADDR_LCON, 32'h8000);
        wait_pulse(1'b0, g);
        check(32'h1, {31'h0, g < 12});
        wr(`PTIC_ADDR_LCON, 32'h0);
        cpu_idle <= 1'b0;
        $display("idle test done");
    endtask
    task t_fifo;
        logic [31:0] r;
        logic [31:0] q;
        int          n;
        wr(`PTIC_ADDR_LPER, 32'hFFFF);
        wr(`PTIC_ADDR_LCON, 32'h8000);
        n = irq_n;
        wr(`PTIC_ADDR_CCON, 32'h00E3);
        PINS.cap_edges(5);
        repeat (8) @(posedge pclk);
        check(32'h1, irq_n - n);
        rd(`PTIC_ADDR_CCON, r);
        check(32'h00FB, r);
        rd(`PTIC_ADDR_CBUF, q);
        for (int i = 0; i < 3; i++)
        begin
            rd(`PTIC_ADDR_CBUF, r);
            check(q + 32'hA, r);
            q = r;
        end
        rd(`PTIC_ADDR_CCON, r);
        check(32'h00E3, r);
        wr(`PTIC_ADDR_LCON, 32'h0);
        $display("capture buffer test done");
    endtask
    task t_modes;
        logic [31:0] r;
        logic [31:0] q;
        int          n;
        int          w;
        int          c;
        wr(`PTIC_ADDR_HCOUNT, 32'h0ABC);
        for (int i = 0; i < 11; i++)
        begin
            wr(`PTIC_ADDR_CCON, 32'h0);
            wr(`PTIC_ADDR_CCON, {16'h0, md_con[i]});
            cpu_sleep <= (i == 9);
            cpu_idle <= (i == 10);
            n = irq_n;
            w = wake_n;
            PINS.cap_edges(md_pulse[i]);
            repeat (8) @(posedge pclk);
            check(md_irq[i], irq_n - n);
            check((i == 9) ? 2 : 0, wake_n - w);
            c = 0;
            rd(`PTIC_ADDR_CCON, r);
            while (r[3] === 1'b1 && c < 8)
            begin
                rd(`PTIC_ADDR_CBUF, q);
                check(32'h0ABC, q);
                c++;
                rd(`PTIC_ADDR_CCON, r);
            end
            check(md_caps[i], c);
        end
        cpu_sleep <= 1'b0;
        cpu_idle <= 1'b0;
        $display("capture mode test done");
    endtask

    // ====
    // Main sequence
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_prescale;
        t_join;
        t_gate_ext;
        t_idle;
        t_fifo;
        t_modes;
        give_verdict;
    end
endmodule // paired_timer_with_input_capture_tb

bind ptic_top ptic_properties u_props (.*);
`default_nettype wire
